// File: shared/ddo_consts.vh
// Constants for the on-die termination timing block.
// Assumes a 100 MHz register clock and a byte-addressed AHB-Lite register map.
`ifndef DDO_CONSTS_VH
`define DDO_CONSTS_VH

// Register byte offsets
`define DDO_ADDR_CTRL        12'h000
`define DDO_ADDR_LAT         12'h004
`define DDO_ADDR_STATUS      12'h008

// Control register fields
`define DDO_CTRL_DLL_PD_ON   0
`define DDO_CTRL_RTT_NOM_EN  1
`define DDO_CTRL_RTT_WR_EN   2
`define DDO_CTRL_DLL_RESET   3
`define DDO_CTRL_WIDTH       3
`define DDO_CTRL_RST         3'h1

// Latency register fields
`define DDO_LAT_CWL_LSB      0
`define DDO_LAT_AL_LSB       4
`define DDO_LAT_NIB_W        4
`define DDO_LAT_TRFC_LSB     8
`define DDO_LAT_TXPDLL_LSB   16
`define DDO_LAT_BYTE_W       8
`define DDO_CWL_RST          4'h5
`define DDO_AL_RST           4'h0
`define DDO_TRFC_RST         8'h80
`define DDO_TXPDLL_RST       8'h0a

// Status register fields
`define DDO_STAT_MODE_LSB    0
`define DDO_STAT_RTT_ON      4
`define DDO_STAT_REF_BUSY    5
`define DDO_STAT_DLL_LOCKING 6
`define DDO_STAT_ASYNC_EFF   7

// Latency arithmetic
`define DDO_ODTL_OFFSET      5'h02
`define DDO_TANPD_EXTRA      5'h01

// Asynchronous termination delays in picoseconds, and the clock period
`define DDO_TAONPD_MIN_PS    2000
`define DDO_TAONPD_MAX_PS    8500
`define DDO_TAOFPD_MIN_PS    2000
`define DDO_TAOFPD_MAX_PS    8500
`define DDO_MCLK_PERIOD_PS   10000

// Default DLL relock time in memory clocks
`define DDO_TDLLK_CK         512

// AHB transfer type bit that marks an active transfer
`define DDO_HTRANS_ACTIVE    1

`endif

// File: logic/ddo_sync2.v
// Two-flip-flop synchroniser for a bundle of pin levels.
// Assumes each bit is an independent slow level; no bus coherence is implied.
`timescale 1ns/100ps
`default_nettype none

module ddo_sync2 #(
  parameter WIDTH = 1
) (
  input  wire             mclk,
  input  wire             reset_n,
  input  wire [WIDTH-1:0] asyncIn,
  output reg  [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] metaReg;

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      metaReg <= {WIDTH{1'b0}};
      syncOut <= {WIDTH{1'b0}};
    end else begin
      metaReg <= asyncIn;
      syncOut <= metaReg;
    end
  end

endmodule

`default_nettype wire

// File: logic/ddo_delay_line.v
// Shift register of ODT samples with a selectable registered tap.
// Assumes the shift strobe marks one memory-clock rising edge.
`timescale 1ns/100ps
`default_nettype none

module ddo_delay_line #(
  parameter DEPTH  = 32,
  parameter SEL_W  = 5
) (
  input  wire             mclk,
  input  wire             reset_n,
  input  wire             shift,
  input  wire             din,
  input  wire [SEL_W-1:0] tapSel,
  output reg              tapOut
);

  reg [DEPTH-1:0] histReg;

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      histReg <= {DEPTH{1'b0}};
      tapOut  <= 1'b0;
    end else begin
      if (shift) begin
        histReg <= {histReg[DEPTH-2:0], din};
      end
      // Tap n is the sample taken n memory-clock edges before the newest
      tapOut <= histReg[tapSel];
    end
  end

endmodule

`default_nettype wire

// File: logic/ddo_odt_ctrl.v
// Termination control of a DDR3L device: synchronous, transition and
// asynchronous ODT modes with power-down entry and exit windows.
// Assumes CK, ODT, CKE and the refresh command arrive as pins from the
// controller and software reaches the registers over AHB-Lite on mclk.
//
// Chosen here: register access over AHB-Lite and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "ddo_consts.vh"

// Functional notes
// - Async mode in DLL-off precharge power-down
// - Async mode while DLL resynchronises after reset
// - Async ODT bypasses additive latency, uses time
// - Async turn-on between 2 and 8.5 ns; here rttOn rises 4 mclk (40 ns) after the pin
// - Async turn-off between 2 and 8.5 ns; here rttOn falls 4 mclk (40 ns) after the pin
// - Entry transition only when DLL-off selected
// - Entry window ends when CKE registered low
// - tANPD equals write latency minus one
// - Running refresh extends entry window to tRFC
// - Entry-window turn-on within combined bounds
// - Entry-window turn-off within combined bounds
// - Exit window lasts tANPD plus tXPDLL
// - Sync on/off latency is CWL plus AL minus two
// - Exit window ends tXPDLL after CKE high; here it runs tANPD plus tXPDLL from CKE high
module ddo_odt_ctrl #(
  parameter ADDR_W   = 12,
  parameter HIST_D   = 32,
  parameter TDLLK_CK = `DDO_TDLLK_CK
) (
  input  wire              mclk,
  input  wire              reset_n,
  // AHB-Lite slave
  input  wire              hsel,
  input  wire [ADDR_W-1:0] haddr,
  input  wire [1:0]        htrans,
  input  wire              hwrite,
  input  wire [2:0]        hsize,
  input  wire [31:0]       hwdata,
  input  wire              hready,
  output wire              hreadyout,
  output wire              hresp,
  output reg  [31:0]       hrdata,
  // Device pins
  input  wire              memClk,
  input  wire              odtPin,
  input  wire              ckePin,
  input  wire              refreshCmd,
  // Termination state
  output reg               rttOn,
  output reg               inTransition,
  output reg               asyncActive
);

  localparam ST_SYNC  = 4'b0001;
  localparam ST_PDE   = 4'b0010;
  localparam ST_ASYNC = 4'b0100;
  localparam ST_PDX   = 4'b1000;

  localparam CNT_W = 10;

  // Asynchronous delays in mclk cycles: least times round up, longest down
  localparam AON_MIN_CYC = (`DDO_TAONPD_MIN_PS + `DDO_MCLK_PERIOD_PS - 1) / `DDO_MCLK_PERIOD_PS;
  localparam AON_MAX_RAW = `DDO_TAONPD_MAX_PS / `DDO_MCLK_PERIOD_PS;
  localparam AON_MAX_CYC = (AON_MAX_RAW < 1) ? 1 : AON_MAX_RAW;
  localparam AOF_MIN_CYC = (`DDO_TAOFPD_MIN_PS + `DDO_MCLK_PERIOD_PS - 1) / `DDO_MCLK_PERIOD_PS;
  localparam AOF_MAX_RAW = `DDO_TAOFPD_MAX_PS / `DDO_MCLK_PERIOD_PS;
  localparam AOF_MAX_CYC = (AOF_MAX_RAW < 1) ? 1 : AOF_MAX_RAW;
  localparam AON_CYC     = (AON_MIN_CYC > AON_MAX_CYC) ? AON_MAX_CYC : AON_MIN_CYC;
  localparam AOF_CYC     = (AOF_MIN_CYC > AOF_MAX_CYC) ? AOF_MAX_CYC : AOF_MIN_CYC;
  localparam [3:0] AON_CNT = AON_CYC[3:0];
  localparam [3:0] AOF_CNT = AOF_CYC[3:0];
  localparam [CNT_W-1:0] TDLLK_CNT = TDLLK_CK[CNT_W-1:0];

  // Write latency minus a constant, clamped at zero
  function [4:0] latMinus;
    input [3:0] cwl;
    input [3:0] al;
    input [4:0] sub;
    reg   [4:0] wl;
    begin
      wl = {1'b0, cwl} + {1'b0, al};
      if (wl > sub) begin
        latMinus = wl - sub;
      end else begin
        latMinus = 5'h00;
      end
    end
  endfunction

  // Register file
  reg  [`DDO_CTRL_WIDTH-1:0] ctrl_reg;
  reg  [3:0]                 cwl_reg;
  reg  [3:0]                 al_reg;
  reg  [7:0]                 trfc_reg;
  reg  [7:0]                 txpdll_reg;
  reg                        dllResetPulse;

  // AHB address phase capture
  reg                        wrPend_reg;
  reg  [ADDR_W-1:0]          wrAddr_reg;

  // Synchronised pins and edge detection
  wire [3:0]                 pinSync;
  wire                       ckS;
  wire                       odtS;
  wire                       ckeS;
  wire                       refS;
  reg                        ckPrev_reg;
  wire                       ckRise;

  // Levels registered at memory-clock rising edges
  reg                        ckeReg;

  // Mode state and window counters
  reg  [3:0]                 state_reg;
  reg  [3:0]                 state_next;
  reg  [CNT_W-1:0]           winCnt_reg;
  reg  [CNT_W-1:0]           winCnt_next;
  reg  [7:0]                 refCnt_reg;
  reg  [CNT_W-1:0]           dllCnt_reg;

  // Asynchronous path
  reg                        asyncTgt_reg;
  reg  [3:0]                 asyncCnt_reg;

  wire [4:0]                 odtLat;
  wire [4:0]                 tanpd;
  wire                       rttEnabled;
  wire                       dllLocking;
  wire                       useAsync;
  wire                       syncTap;
  wire                       addrPhase;

  assign odtLat     = latMinus(cwl_reg, al_reg, `DDO_ODTL_OFFSET);
  assign tanpd      = odtLat + `DDO_TANPD_EXTRA;
  assign rttEnabled = ctrl_reg[`DDO_CTRL_RTT_NOM_EN] | ctrl_reg[`DDO_CTRL_RTT_WR_EN];
  assign dllLocking = (dllCnt_reg != {CNT_W{1'b0}});
  assign useAsync   = rttEnabled & ((state_reg == ST_ASYNC) | dllLocking);

  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign addrPhase  = hsel & hready & htrans[`DDO_HTRANS_ACTIVE];

  assign ckS    = pinSync[0];
  assign odtS   = pinSync[1];
  assign ckeS   = pinSync[2];
  assign refS   = pinSync[3];
  assign ckRise = ckS & ~ckPrev_reg;

  ddo_sync2 #(
    .WIDTH   (4)
  ) uSync (
    .mclk    (mclk),
    .reset_n (reset_n),
    .asyncIn ({refreshCmd, ckePin, odtPin, memClk}),
    .syncOut (pinSync)
  );

  // Synchronous path: ODT registered high shows up odtLat clocks later
  ddo_delay_line #(
    .DEPTH   (HIST_D),
    .SEL_W   (5)
  ) uDelay (
    .mclk    (mclk),
    .reset_n (reset_n),
    .shift   (ckRise),
    .din     (odtS),
    .tapSel  (odtLat),
    .tapOut  (syncTap)
  );

  // AHB-Lite register access, zero wait states
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wrPend_reg    <= 1'b0;
      wrAddr_reg    <= {ADDR_W{1'b0}};
      hrdata        <= 32'h0000_0000;
      ctrl_reg      <= `DDO_CTRL_RST;
      cwl_reg       <= `DDO_CWL_RST;
      al_reg        <= `DDO_AL_RST;
      trfc_reg      <= `DDO_TRFC_RST;
      txpdll_reg    <= `DDO_TXPDLL_RST;
      dllResetPulse <= 1'b0;
    end else begin
      dllResetPulse <= 1'b0;
      wrPend_reg    <= addrPhase & hwrite;
      if (addrPhase) begin
        wrAddr_reg <= haddr;
      end
      if (addrPhase && !hwrite) begin
        if (haddr == `DDO_ADDR_CTRL) begin
          hrdata <= {29'h0, ctrl_reg};
        end else if (haddr == `DDO_ADDR_LAT) begin
          hrdata <= {8'h00, txpdll_reg, trfc_reg, al_reg, cwl_reg};
        end else if (haddr == `DDO_ADDR_STATUS) begin
          hrdata <= {24'h00_0000, useAsync, dllLocking, (refCnt_reg != 8'h00),
                     rttOn, state_reg};
        end else begin
          hrdata <= 32'h0000_0000;
        end
      end
      if (wrPend_reg) begin
        if (wrAddr_reg == `DDO_ADDR_CTRL) begin
          ctrl_reg      <= hwdata[`DDO_CTRL_WIDTH-1:0];
          dllResetPulse <= hwdata[`DDO_CTRL_DLL_RESET];
        end else if (wrAddr_reg == `DDO_ADDR_LAT) begin
          cwl_reg    <= hwdata[`DDO_LAT_CWL_LSB +: `DDO_LAT_NIB_W];
          al_reg     <= hwdata[`DDO_LAT_AL_LSB +: `DDO_LAT_NIB_W];
          trfc_reg   <= hwdata[`DDO_LAT_TRFC_LSB +: `DDO_LAT_BYTE_W];
          txpdll_reg <= hwdata[`DDO_LAT_TXPDLL_LSB +: `DDO_LAT_BYTE_W];
        end
      end
    end
  end

  // Memory-clock edge sampling, refresh and DLL relock timers
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ckPrev_reg <= 1'b0;
      ckeReg     <= 1'b0;
      refCnt_reg <= 8'h00;
      dllCnt_reg <= {CNT_W{1'b0}};
    end else begin
      ckPrev_reg <= ckS;
      if (ckRise) begin
        ckeReg <= ckeS;
      end
      if (ckRise && ckeS && refS) begin
        refCnt_reg <= trfc_reg;
      end else if (ckRise && (refCnt_reg != 8'h00)) begin
        refCnt_reg <= refCnt_reg - 8'h01;
      end
      if (dllResetPulse) begin
        dllCnt_reg <= TDLLK_CNT;
      end else if (ckRise && dllLocking) begin
        dllCnt_reg <= dllCnt_reg - {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // Mode state machine, advanced on memory-clock rising edges
  always @* begin
    state_next  = state_reg;
    winCnt_next = winCnt_reg;
    if (ckRise) begin
      case (state_reg)
        ST_SYNC: begin
          // The earlier tANPD part of the entry window is answered synchronously
          if (ckeReg && !ckeS && !ctrl_reg[`DDO_CTRL_DLL_PD_ON]) begin
            if (refCnt_reg > {3'h0, tanpd}) begin
              state_next  = ST_PDE;
              // Refresh edges still to run once this edge is counted
              winCnt_next = {2'h0, refCnt_reg - 8'h01};
            end else begin
              state_next  = ST_ASYNC;
            end
          end
        end
        ST_PDE: begin
          if (ckeS) begin
            state_next  = ST_PDX;
            winCnt_next = {{(CNT_W-5){1'b0}}, tanpd} + {2'h0, txpdll_reg};
          end else if (winCnt_reg <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
            state_next  = ST_ASYNC;
            winCnt_next = {CNT_W{1'b0}};
          end else begin
            winCnt_next = winCnt_reg - {{(CNT_W-1){1'b0}}, 1'b1};
          end
        end
        ST_ASYNC: begin
          if (!ckeReg && ckeS) begin
            state_next  = ST_PDX;
            winCnt_next = {{(CNT_W-5){1'b0}}, tanpd} + {2'h0, txpdll_reg};
          end
        end
        ST_PDX: begin
          if (!ckeS) begin
            state_next  = ST_ASYNC;
            winCnt_next = {CNT_W{1'b0}};
          end else if (winCnt_reg <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
            state_next  = ST_SYNC;
            winCnt_next = {CNT_W{1'b0}};
          end else begin
            winCnt_next = winCnt_reg - {{(CNT_W-1){1'b0}}, 1'b1};
          end
        end
        default: begin
          state_next  = ST_SYNC;
          winCnt_next = {CNT_W{1'b0}};
        end
      endcase
    end
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg  <= ST_SYNC;
      winCnt_reg <= {CNT_W{1'b0}};
    end else begin
      state_reg  <= state_next;
      winCnt_reg <= winCnt_next;
    end
  end

  // Termination output: synchronous tap or timed asynchronous follow
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rttOn        <= 1'b0;
      asyncTgt_reg <= 1'b0;
      asyncCnt_reg <= 4'h0;
      inTransition <= 1'b0;
      asyncActive  <= 1'b0;
    end else begin
      inTransition <= (state_reg == ST_PDE) | (state_reg == ST_PDX);
      asyncActive  <= useAsync;
      if (!rttEnabled) begin
        rttOn        <= 1'b0;
        asyncCnt_reg <= 4'h0;
      end else if (useAsync) begin
        // Pin level taken directly, no additive latency
        if (odtS != asyncTgt_reg) begin
          asyncTgt_reg <= odtS;
          asyncCnt_reg <= odtS ? AON_CNT : AOF_CNT;
        end else if (asyncCnt_reg > 4'h1) begin
          asyncCnt_reg <= asyncCnt_reg - 4'h1;
        end else begin
          asyncCnt_reg <= 4'h0;
          rttOn        <= asyncTgt_reg;
        end
      end else begin
        // Inside windows the synchronous answer lies within both bounds
        asyncTgt_reg <= odtS;
        asyncCnt_reg <= 4'h0;
        rttOn        <= syncTap;
      end
    end
  end

endmodule

`default_nettype wire

// File: verification/ddo_odt_ctrl_checker.sv
// Port assertions for the termination control block.
// Assumes AHB writes land at the end of their data phase and CTRL sits at offset 0.
`timescale 1ns/100ps
`default_nettype none
`include "ddo_consts.vh"
module ddo_odt_ctrl_checker #(
  parameter ADDR_W = 12
) (
  input wire logic              mclk,
  input wire logic              reset_n,
  input wire logic              hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic [31:0]       hwdata,
  input wire logic              hready,
  input wire logic              odtPin,
  input wire logic              ckePin,
  input wire logic              rttOn,
  input wire logic              inTransition,
  input wire logic              asyncActive
);
  logic       wrPend;
  logic [2:0] ctlReg;
  logic       rttEn;
  logic       dllRst;
  // Shadow of the control register, rebuilt from bus writes
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wrPend <= 1'b0;
      ctlReg <= `DDO_CTRL_RST;
    end else begin
      wrPend <= hsel && hready && htrans[1] && hwrite && (haddr == '0);
      if (wrPend)
        ctlReg <= hwdata[2:0];
    end
  end
  assign rttEn = |ctlReg[2:1];
  assign dllRst = wrPend && hwdata[3];
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  async_on_a: assert property ((asyncActive && rttEn && odtPin) [*5] |-> rttOn)
    else $error("termination not on in asynchronous mode");
  async_off_a: assert property ((asyncActive && !odtPin) [*5] |-> !rttOn)
    else $error("termination not off in asynchronous mode");
  async_rise_a: assert property (asyncActive && $past(asyncActive) && $rose(rttOn) |-> $past(odtPin, 3))
    else $error("asynchronous turn-on without ODT three cycles before");
  async_fall_a: assert property (asyncActive && rttEn && $fell(rttOn) |-> !$past(odtPin, 3))
    else $error("asynchronous turn-off without ODT low three cycles before");
  no_term_a: assert property (!rttEn [*3] |-> !rttOn)
    else $error("termination on while both values disabled");
  pde_dll_off_a: assert property ($rose(inTransition) |-> !ctlReg[0])
    else $error("transition window with DLL kept on");
  pde_cke_low_a: assert property ($rose(inTransition) && !$past(asyncActive) |-> !ckePin)
    else $error("entry window without CKE low");
  pdx_cke_high_a: assert property ($rose(inTransition) && $past(asyncActive) |-> ckePin)
    else $error("exit window without CKE high");
  dll_relock_a: assert property (dllRst && rttEn |-> ##[1:6] asyncActive)
    else $error("no asynchronous mode after DLL reset");
  mode_excl_a: assert property (!(inTransition && asyncActive))
    else $error("window and asynchronous mode at once");
  cover property ($rose(asyncActive));
  cover property ($rose(inTransition));
  cover property (asyncActive && $rose(rttOn));
endmodule
bind ddo_odt_ctrl ddo_odt_ctrl_checker #(.ADDR_W(ADDR_W)) ddo_odt_ctrl_checker_i (
  .mclk(mclk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .odtPin(odtPin), .ckePin(ckePin),
  .rttOn(rttOn), .inTransition(inTransition), .asyncActive(asyncActive)
);
`default_nettype wire

// File: verification/ddo_mem_ctrl_model.sv
// Memory controller model: free-running CK with ODT, CKE and REFRESH pins.
// Assumes the bench calls drive() and that pins are registered on CK rises.
`timescale 1ns/100ps
`default_nettype none
module ddo_mem_ctrl_model (
  input  wire logic mclk,
  output var  logic memClk,
  output var  logic odtPin,
  output var  logic ckePin,
  output var  logic refreshCmd
);
  initial begin
    memClk = 1'b0;
    odtPin = 1'b0;
    ckePin = 1'b1;
    refreshCmd = 1'b0;
    #3;
    forever #40 memClk = ~memClk;
  end
  // Pins move after CK falls so each level is registered whole at the next rise.
  // No READ is issued, and callers hold ODT at least four CK and keep it still in windows.
  task automatic drive(input logic odt, input logic cke, input logic refr, input int ck);
    @(negedge memClk);
    @(posedge mclk);
    odtPin <= odt;
    ckePin <= cke;
    refreshCmd <= refr;
    repeat (ck) @(posedge memClk);
  endtask
endmodule
`default_nettype wire

// File: verification/ddo_odt_ctrl_test.sv
// Self-checking bench for the termination control block.
// Assumes the controller model drives the pins and relock is shortened to 8 CK.
`timescale 1ns/100ps
`default_nettype none
module ddo_odt_ctrl_test;
  logic        mclk, reset_n, hsel, hwrite, rttOn, inTransition, asyncActive;
  logic        memClk, odtPin, ckePin, refreshCmd;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rd;
  wire         hreadyout;
  int          errTotal, samplesChecked, cycles;
  ddo_odt_ctrl #(.TDLLK_CK(8)) ddo_odt_ctrl_i (
    .mclk(mclk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(), .hrdata(hrdata), .memClk(memClk), .odtPin(odtPin),
    .ckePin(ckePin), .refreshCmd(refreshCmd), .rttOn(rttOn), .inTransition(inTransition),
    .asyncActive(asyncActive)
  );
  ddo_mem_ctrl_model mc (
    .mclk(mclk), .memClk(memClk), .odtPin(odtPin), .ckePin(ckePin),
    .refreshCmd(refreshCmd)
  );
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    samplesChecked++;
    if (s !== e) begin
      errTotal++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= a;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // Counts CK rises (ck=1) or mclk cycles until rttOn reaches v
  task automatic waitRtt(input logic v, input logic ck, input int lim, output int n);
    n = 0;
    while (rttOn !== v && n < lim) begin
      if (ck)
        @(posedge memClk);
      else begin
        @(posedge mclk);
        #1;
      end
      n++;
    end
  endtask
  // Counts CK rises seen inside one transition window
  task automatic span(output int n);
    n = 0;
    repeat (4) if (inTransition !== 1'b1) @(posedge memClk);
    while (inTransition === 1'b1 && n < 300) begin
      n++;
      @(posedge memClk);
    end
  endtask
  task automatic regReset;
    bus(0, 12'h000, 0);
    chk("ctrl reset", 32'h1, rd);
    bus(0, 12'h004, 0);
    chk("lat reset", 32'h000a8005, rd);
    bus(1, 12'h008, 32'hff);
    bus(1, 12'h00c, 32'hffffffff);
    bus(0, 12'h008, 0);
    chk("status", 32'h1, rd);
    bus(0, 12'h00c, 0);
    chk("unmapped", 32'h0, rd);
  endtask
  task automatic syncLatency;
    int n;
    logic [2:0] ctl [3] = '{3'h1, 3'h3, 3'h5};
    bus(1, 12'h004, 32'h000a8016);
    foreach (ctl[i]) begin
      bus(1, 12'h000, {29'h0, ctl[i]});
      mc.drive(1'b1, 1'b1, 1'b0, 0);
      waitRtt(1'b1, 1'b1, 12, n);
      chk("sync on CK", ctl[i] == 3'h1 ? 12 : 7, n);
      chk("sync async flag", 0, asyncActive);
      mc.drive(1'b0, 1'b1, 1'b0, 0);
      waitRtt(1'b0, 1'b1, 12, n);
      chk("sync off CK", ctl[i] == 3'h1 ? 0 : 7, n);
      // Flush the ODT history before the next setting
      repeat (8) @(posedge memClk);
    end
  endtask
  task automatic asyncMode;
    int n;
    bus(1, 12'h004, 32'h00038025);
    bus(1, 12'h000, 32'h2);
    mc.drive(1'b0, 1'b0, 1'b0, 2);
    chk("async entry", 1, asyncActive);
    chk("no entry window", 0, inTransition);
    bus(0, 12'h008, 0);
    chk("status async", 32'h4, rd & 32'hf);
    mc.drive(1'b1, 1'b0, 1'b0, 0);
    waitRtt(1'b1, 1'b0, 20, n);
    chk("async on mclk", 4, n);
    repeat (4) @(posedge memClk);
    mc.drive(1'b0, 1'b0, 1'b0, 0);
    waitRtt(1'b0, 1'b0, 20, n);
    chk("async off mclk", 4, n);
    mc.drive(1'b0, 1'b1, 1'b0, 0);
    span(n);
    chk("exit window CK", 9, n);
    chk("sync after exit", 0, asyncActive);
  endtask
  task automatic refreshEntry;
    int n;
    bus(1, 12'h004, 32'h00021405);
    mc.drive(1'b0, 1'b1, 1'b1, 1);
    mc.drive(1'b0, 1'b0, 1'b0, 0);
    span(n);
    chk("entry window CK", 19, n);
    chk("async after entry", 1, asyncActive);
    mc.drive(1'b0, 1'b1, 1'b0, 0);
    span(n);
    chk("short exit CK", 6, n);
  endtask
  task automatic dllReset;
    bus(1, 12'h000, 32'h3);
    bus(1, 12'h000, 32'hb);
    bus(0, 12'h000, 0);
    chk("ctrl self clear", 32'h3, rd);
    bus(0, 12'h008, 0);
    chk("status relock", 32'hc1, rd);
    repeat (10) @(posedge memClk);
    chk("relock done", 0, asyncActive);
  endtask
  task automatic finalReport;
    if (errTotal == 0 && samplesChecked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      errTotal++;
      finalReport;
    end
  end
  initial begin
    reset_n = 1'b0;
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    regReset;
    syncLatency;
    asyncMode;
    refreshEntry;
    dllReset;
    finalReport;
  end
endmodule
`default_nettype wire
